// >>> include/vfdscp_pkg.sv
// Constants, types and carriers for the serial command port of the display driver.
// Assumes a single 10 MHz system clock; the host link pins are asynchronous to it.
package vfdscp_pkg;

    localparam int unsigned CLK_HZ   = 10_000_000;
    localparam int unsigned OSC_HZ   = 2_250_000;
    localparam int unsigned OSC_DIV  = (CLK_HZ / OSC_HZ < 1) ? 1 : CLK_HZ / OSC_HZ;
    localparam int unsigned OSC_CYC_PER_BIT = 4;

    localparam int unsigned SEG_W    = 32;
    localparam int unsigned DIM_W    = 10;
    localparam int unsigned MODE_W   = 3;
    localparam int unsigned GRID_N   = 3;
    localparam int unsigned SR_W     = SEG_W + MODE_W;

    // Field positions inside the shift register after a frame ends
    localparam int unsigned MODE_LSB = SEG_W;
    localparam int unsigned DIM_LSB  = SEG_W - DIM_W;

    localparam logic [2:0]  MODE_ALL   = 3'h0;
    localparam logic [2:0]  MODE_GRID1 = 3'h1;
    localparam logic [2:0]  MODE_GRID3 = 3'h3;
    localparam logic [2:0]  MODE_DIM   = 3'h4;

    localparam logic [9:0]  DUTY_MAX   = 10'h3f8;
    localparam logic [9:0]  DUTY_RST   = 10'h000;
    localparam logic [2:0]  GRID_RST   = 3'h7;

    typedef enum logic [2:0] {
        VFDSCP_IDLE  = 3'b001,
        VFDSCP_FRAME = 3'b010,
        VFDSCP_LOAD  = 3'b100
    } vfdscp_state_e;

    typedef struct packed {
        logic chip_sel;
        logic shift_clk;
        logic ser_data;
    } vfdscp_link_s;

    typedef struct packed {
        logic [SEG_W-1:0]  anode_outputs;
        logic [GRID_N-1:0] cathode_group_outputs;
    } vfdscp_drive_s;

endpackage

// >>> verilog/vfdscp_latch_bank.sv
// Bank of per-grid segment latches with a registered read port.
// Assumes the writer raises at most the enables it means in one cycle.
`timescale 1ns/1ps
module vfdscp_latch_bank #(
    parameter int unsigned W = 32,
    parameter int unsigned N = 3
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rstn,
    // Write side
    input  wire logic [N-1:0] wr_en,
    input  wire logic [W-1:0] wr_data,
    // Read side
    input  wire logic [1:0]   rd_idx,
    output logic      [W-1:0] rd_data
);
    logic [W-1:0] word_reg [N];

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_word
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    word_reg[gi] <= '0; // R01
                end else if (wr_en[gi]) begin
                    word_reg[gi] <= wr_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rd_data <= '0;
        end else if (32'(rd_idx) < N) begin
            rd_data <= word_reg[rd_idx];
        end else begin
            rd_data <= '0;
        end
    end
endmodule

// >>> verilog/vfdscp_top.sv
// Serial command port and output multiplexer of a triplex display driver.
// Assumes link pins arrive asynchronously; reset is the internal power-on reset.
// How it works
// [R01] Power-up clears shift register and latches
// [R02] Brightness stays zero until host writes it
// [R03] After reset segments low, grids high
// [R04] Shifting only while chip select is high
// [R05] Data sampled on shift clock rising edge
// [R06] Host sends mode bits last
// [R07] Chip select fall fires one load strobe
// [R08] Mode bits select all, grid, or brightness
// [R09] Mode zero writes all grids, codes one to three one
// [R10] Brightness ten bits LSB first, thirteen total
// [R11] Duty n/1024, clamped at 1016/1024
// [R12] Latched one drives its segment high
// [R13] Codes five to seven are discarded
// [R14] Bit period is four oscillator cycles
`timescale 1ns/1ps
module vfdscp_top
    import vfdscp_pkg::*;
#(
    parameter int unsigned OSC_DIVIDE = OSC_DIV
) (
    // Clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    rstn,
    // Host link pins
    input  wire vfdscp_pkg::vfdscp_link_s link_in,
    // Duty select pin, high for two grids
    input  wire logic                    duplex_sel,
    // Display drive
    output vfdscp_pkg::vfdscp_drive_s    drive_out,
    // Status
    output logic [9:0]                   duty_code,
    output logic                         load_pulse,
    output logic                         frame_discard
);
    import vfdscp_pkg::*;

    typedef struct packed {
        logic             cs_m;
        logic             cs_s;
        logic             cs_d;
        logic             ck_m;
        logic             ck_s;
        logic             ck_d;
        logic             dt_m;
        logic             dt_s;
        logic             dup_m;
        logic             dup_s;
        vfdscp_state_e    st;
        logic [SR_W-1:0]  sr;
        logic [9:0]       duty;
        logic [2:0]       wr_en;
        logic [SEG_W-1:0] wr_data;
        logic             load;
        logic             discard;
        logic [7:0]       div;
        logic [1:0]       osc_cnt;
        logic             bit_tick;
        logic [9:0]       pwm;
        logic [1:0]       grid;
        logic [1:0]       grid_d;
        logic             scan;
        logic             gate;
        logic [SEG_W-1:0] anode;
        logic [2:0]       cathode;
    } vfdscp_core_s;

    vfdscp_core_s s_reg;
    vfdscp_core_s s_next;
    logic [SEG_W-1:0] rd_data;

    localparam logic [7:0] DIV_LAST = 8'(OSC_DIVIDE - 1);
    localparam logic [1:0] BIT_LAST = 2'(OSC_CYC_PER_BIT - 1);

    logic       cs_fall;
    logic       ck_rise;
    logic [2:0] mode;
    logic [9:0] duty_eff;
    logic [1:0] grid_last;
    logic       osc_en;

    always_comb begin
        cs_fall   = s_reg.cs_d & ~s_reg.cs_s;
        ck_rise   = ~s_reg.ck_d & s_reg.ck_s;
        mode      = {s_reg.sr[MODE_LSB+2], s_reg.sr[MODE_LSB+1], s_reg.sr[MODE_LSB]};
        duty_eff  = (s_reg.duty > DUTY_MAX) ? DUTY_MAX : s_reg.duty; // R11
        grid_last = s_reg.dup_s ? 2'h1 : 2'h2;
        osc_en    = (s_reg.div == DIV_LAST);

        s_next = s_reg;
        // Second stage only reads the first; logic sees second and later
        s_next.cs_m  = link_in.chip_sel;
        s_next.cs_s  = s_reg.cs_m;
        s_next.cs_d  = s_reg.cs_s;
        s_next.ck_m  = link_in.shift_clk;
        s_next.ck_s  = s_reg.ck_m;
        s_next.ck_d  = s_reg.ck_s;
        s_next.dt_m  = link_in.ser_data;
        s_next.dt_s  = s_reg.dt_m;
        s_next.dup_m = duplex_sel;
        s_next.dup_s = s_reg.dup_m;
        s_next.wr_en   = 3'h0;
        s_next.load    = 1'b0;
        s_next.discard = 1'b0;

        case (s_reg.st)
            VFDSCP_IDLE: begin
                // Clock edges with chip select low never reach the register
                if (s_reg.cs_s && !s_reg.cs_d) begin
                    s_next.st = VFDSCP_FRAME; // R04
                end
            end
            VFDSCP_FRAME: begin
                if (cs_fall) begin
                    s_next.st = VFDSCP_LOAD; // R07
                end else if (ck_rise) begin
                    // Newest bit enters at the top, so mode bits end at the top
                    s_next.sr = {s_reg.dt_s, s_reg.sr[SR_W-1:1]}; // R05 R06
                end
            end
            VFDSCP_LOAD: begin
                s_next.st   = VFDSCP_IDLE;
                s_next.load = 1'b1; // R07
                s_next.wr_data = s_reg.sr[SEG_W-1:0];
                if (mode == MODE_ALL) begin
                    s_next.wr_en = 3'h7; // R08 R09
                end else if (mode >= MODE_GRID1 && mode <= MODE_GRID3) begin
                    s_next.wr_en = 3'(3'h1 << (mode - MODE_GRID1)); // R08 R09
                end else if (mode == MODE_DIM) begin
                    s_next.duty = s_reg.sr[DIM_LSB+DIM_W-1:DIM_LSB]; // R08 R10 R02
                end else begin
                    s_next.discard = 1'b1; // R13
                end
            end
            default: begin
                s_next.st = VFDSCP_IDLE;
            end
        endcase

        // Oscillator stand-in: a divided enable, four of them per bit time
        s_next.bit_tick = 1'b0;
        s_next.div = osc_en ? 8'h00 : s_reg.div + 8'h01;
        if (osc_en) begin
            s_next.osc_cnt = s_reg.osc_cnt + 2'h1;
            if (s_reg.osc_cnt == BIT_LAST) begin
                s_next.bit_tick = 1'b1; // R14
            end
        end
        if (s_reg.bit_tick) begin
            s_next.scan = 1'b1;
            s_next.pwm  = s_reg.pwm + 10'h001;
            if (s_reg.pwm == 10'h3ff) begin
                s_next.grid = (s_reg.grid >= grid_last) ? 2'h0 : s_reg.grid + 2'h1;
            end
        end

        // Pipeline lines up with the registered latch read
        s_next.grid_d = s_reg.grid;
        s_next.gate   = s_reg.pwm < duty_eff; // R11
        s_next.anode  = s_reg.gate ? rd_data : '0; // R12
        if (s_reg.scan) begin
            s_next.cathode = s_reg.gate ? 3'(3'h1 << s_reg.grid_d) : 3'h0;
        end else begin
            s_next.cathode = GRID_RST; // R03
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_reg         <= '0; // R01 R03
            s_reg.st      <= VFDSCP_IDLE;
            s_reg.duty    <= DUTY_RST; // R02
            s_reg.cathode <= GRID_RST; // R03
        end else begin
            s_reg <= s_next;
        end
    end

    vfdscp_latch_bank #(
        .W (SEG_W),
        .N (GRID_N)
    ) u_bank (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .wr_en   (s_reg.wr_en),
        .wr_data (s_reg.wr_data),
        .rd_idx  (s_reg.grid),
        .rd_data (rd_data)
    );

    // One driver for the whole carrier keeps it a single continuous assignment
    assign drive_out     = {s_reg.anode, s_reg.cathode};
    assign duty_code     = s_reg.duty;
    assign load_pulse    = s_reg.load;
    assign frame_discard = s_reg.discard;

    a_idle_no_shift: assert property (@(posedge sys_clk) disable iff (!rstn) // R04
        (s_reg.st == VFDSCP_IDLE) |=> $stable(s_reg.sr))
        else $error("shift register moved outside a frame");

    a_rise_sample: assert property (@(posedge sys_clk) disable iff (!rstn) // R05
        (s_reg.st == VFDSCP_FRAME && ck_rise && !cs_fall)
        |=> (s_reg.sr[SR_W-1] == $past(s_reg.dt_s)) && (s_reg.sr[SR_W-2:0] == $past(s_reg.sr[SR_W-1:1])))
        else $error("serial bit not taken on clock rise");

    a_fall_strobe: assert property (@(posedge sys_clk) disable iff (!rstn) // R07
        (s_reg.st == VFDSCP_FRAME && cs_fall) |=> ##1 s_reg.load ##1 !s_reg.load)
        else $error("no single load strobe after chip select fall");

    a_mode_all: assert property (@(posedge sys_clk) disable iff (!rstn) // R09
        (s_reg.st == VFDSCP_LOAD && mode == MODE_ALL)
        |=> s_reg.wr_en == 3'h7 && s_reg.wr_data == $past(s_reg.sr[SEG_W-1:0]))
        else $error("mode zero did not write every grid");

    a_mode_grid: assert property (@(posedge sys_clk) disable iff (!rstn) // R08
        (s_reg.st == VFDSCP_LOAD && mode == 3'h2) |=> s_reg.wr_en == 3'h2 ##1 s_reg.wr_en == 3'h0)
        else $error("grid two code did not write only grid two");

    a_dim_load: assert property (@(posedge sys_clk) disable iff (!rstn) // R10
        (s_reg.st == VFDSCP_LOAD && mode == MODE_DIM)
        |=> s_reg.duty == $past(s_reg.sr[SR_W-4:SR_W-13]) && s_reg.wr_en == 3'h0)
        else $error("brightness field not loaded");

    a_bad_code: assert property (@(posedge sys_clk) disable iff (!rstn) // R13
        (s_reg.st == VFDSCP_LOAD && mode > MODE_DIM)
        |=> s_reg.discard && s_reg.wr_en == 3'h0 && $stable(s_reg.duty))
        else $error("reserved code changed a latch");

    a_duty_hold: assert property (@(posedge sys_clk) disable iff (!rstn) // R02
        !(s_reg.st == VFDSCP_LOAD && mode == MODE_DIM) |=> $stable(s_reg.duty))
        else $error("brightness changed without a write");

    a_duty_clamp: assert property (@(posedge sys_clk) disable iff (!rstn) // R11
        (s_reg.anode != '0) |-> ($past(s_reg.pwm, 2) < DUTY_MAX))
        else $error("segments lit beyond the duty ceiling");

    a_bit_period: assert property (@(posedge sys_clk) disable iff (!rstn) // R14
        s_reg.bit_tick |-> $past(s_reg.osc_cnt) == BIT_LAST && $past(osc_en))
        else $error("bit time is not four oscillator cycles");
endmodule

// >>> bench/vfdscp_host.sv
// Host model: drives chip select, shift clock and serial data of the link.
// Assumes each task is entered just after a falling edge of the system clock.
`timescale 1ns/1ps
module vfdscp_host (
    // Link toward the device
    output vfdscp_pkg::vfdscp_link_s link
);
    import vfdscp_pkg::*;

    initial link = '0;

    // 400 ns per phase keeps setup, hold, width and chip select margins
    task automatic frame(input logic [34:0] bits, input int n);
        link.chip_sel = 1'b1;
        #400;
        for (int i = 0; i < n; i++) begin
            link.ser_data = bits[i];
            #400 link.shift_clk = 1'b1;
            #400 link.shift_clk = 1'b0;
        end
        #400 link.chip_sel = 1'b0;
        // Released line shows the inverse, so a stale level is never trusted
        link.ser_data = ~link.ser_data;
        #20000;
    endtask

    // Shift edges with chip select low, which the device has to ignore
    task automatic stray(input int n);
        for (int i = 0; i < n; i++) begin
            link.ser_data = i[0];
            #400 link.shift_clk = 1'b1;
            #400 link.shift_clk = 1'b0;
        end
    endtask
endmodule

// >>> bench/test_vfdscp_top.sv
// Self-checking bench for the serial command port and its output scan.
// Assumes the scan divider is shortened to one system clock per oscillator cycle.
`timescale 1ns/1ps
module test_vfdscp_top;
    import vfdscp_pkg::*;

    logic          sys_clk    = 1'b0;
    logic          rstn       = 1'b0;
    logic          duplex_sel = 1'b0;
    vfdscp_link_s  link;
    vfdscp_drive_s drive;
    logic [9:0]    duty_code;
    logic          load_pulse;
    logic          frame_discard;
    logic [31:0]   seed       = 32'h02d1e825;
    logic [31:0]   pat [5];
    int            n_fail     = 0;
    int            check_count = 0;
    int            n_load     = 0;
    int            n_disc     = 0;

    vfdscp_top #(.OSC_DIVIDE(1)) dut (.sys_clk(sys_clk), .rstn(rstn), .link_in(link),
        .duplex_sel(duplex_sel), .drive_out(drive), .duty_code(duty_code),
        .load_pulse(load_pulse), .frame_discard(frame_discard));
    vfdscp_host host (.link(link));

    initial forever #50 sys_clk = ~sys_clk;

    // Pulses are counted mid-cycle, where they stand settled
    always @(negedge sys_clk) begin
        if (load_pulse === 1'b1) n_load++;
        if (frame_discard === 1'b1) n_disc++;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic send(input logic [34:0] bits, input int n);
        int l;
        int d;
        l = n_load;
        d = n_disc;
        @(negedge sys_clk);
        host.frame(bits, n);
        chk("load count", l + 1, n_load);
        chk("discard count", d + (bits[n-3 +: 3] >= 3'h5), n_disc);
    endtask

    // Waits for the start of a grid slot so the sample lands inside its window
    task automatic grid(input int g, input logic [31:0] exp);
        logic [2:0] w;
        logic [2:0] p;
        w = 3'(1 << g);
        p = w;
        for (int i = 0; i < 20000 && !(p !== w && drive.cathode_group_outputs === w); i++) begin
            p = drive.cathode_group_outputs;
            @(negedge sys_clk);
        end
        repeat (8) @(negedge sys_clk);
        chk("grid drive", 32'(w), 32'(drive.cathode_group_outputs));
        chk("segments", exp, drive.anode_outputs);
    endtask

    // Starts with the slot after the one now lit, so three slots cost one scan at most
    task automatic grids(input logic [31:0] e0, input logic [31:0] e1, input logic [31:0] e2);
        logic [31:0] e [3];
        int          g;
        e[0] = e0;
        e[1] = e1;
        e[2] = e2;
        for (int i = 0; i < 200 && drive.cathode_group_outputs === 3'h0; i++) begin
            @(negedge sys_clk);
        end
        g = 0;
        if (drive.cathode_group_outputs === 3'h2) begin
            g = 1;
        end else if (drive.cathode_group_outputs === 3'h4) begin
            g = 2;
        end
        grid((g + 1) % 3, e[(g + 1) % 3]);
        grid((g + 2) % 3, e[(g + 2) % 3]);
        grid(g, e[g]);
    endtask

    // One full dimming period, so the lit count does not depend on phase
    task automatic duty_chk(input logic [9:0] code);
        int on;
        on = 0;
        send(35'({3'h4, code}), 13);
        chk("duty code", 32'(code), 32'(duty_code));
        repeat (1024 * OSC_CYC_PER_BIT) begin
            @(negedge sys_clk);
            on += (drive.cathode_group_outputs !== 3'h0);
        end
        chk("lit cycles", OSC_CYC_PER_BIT * (code > 10'h3f8 ? 1016 : code), on);
    endtask

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #10_000_000;
        n_fail++;
        $display("unexpected watchdog: expected finish, seen timeout");
        wrap_up();
    end

    initial begin
        repeat (5) @(negedge sys_clk);
        rstn = 1'b1;
        chk("reset segments", 32'h0, drive.anode_outputs);
        chk("reset grids", 32'h7, 32'(drive.cathode_group_outputs));
        chk("reset duty", 32'h0, 32'(duty_code));
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            seed = lfsr(seed);
            pat[i] = seed;
        end
        duty_chk({4'h0, seed[5:0]});
        duty_chk(10'h3ff);
        $display("test brightness done");
        grids(32'h0, 32'h0, 32'h0);
        send({3'h0, pat[0]}, 35);
        grids(pat[0], pat[0], pat[0]);
        send({3'h2, pat[1]}, 35);
        grids(pat[0], pat[1], pat[0]);
        send({3'h1, pat[2]}, 35);
        send({3'h3, pat[3]}, 35);
        for (int c = 5; c < 8; c++) send({3'(c), pat[4]}, 35);
        grids(pat[2], pat[1], pat[3]);
        $display("test segments done");
        @(negedge sys_clk);
        host.stray(3);
        send(35'(3'h1), 3);
        grids({3'h7, pat[4][31:3]}, pat[1], pat[3]);
        $display("test framing done");
        wrap_up();
    end
endmodule
